// ### src/fsp_axil_slave.sv
`timescale 1ns/10ps
`default_nettype none
module fsp_axil_slave (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// write address and data
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// read address and data
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// register file side
	fsp_reg_if.slave         rf
);
	logic        aw_ok_r;   // address held
	logic        w_ok_r;    // data held
	logic [7:0]  awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;
	wire         do_wr = aw_ok_r & w_ok_r & ~bvalid_r;  // both halves in
	wire         do_rd = arvalid & arready;

	// ----------------------------------------------------------------
	// handshakes, frozen while ce is low
	// ----------------------------------------------------------------
	assign awready = ce & ~aw_ok_r & ~bvalid_r;
	assign wready  = ce & ~w_ok_r & ~bvalid_r;
	assign arready = ce & ~rvalid_r;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign rvalid  = rvalid_r;
	assign rdata   = rdata_r;
	assign rresp   = rresp_r;
	assign rf.wr_en   = ce & do_wr;
	assign rf.wr_addr = awaddr_r;
	assign rf.wr_data = wdata_r;
	assign rf.wr_strb = wstrb_r;
	assign rf.rd_addr = araddr;

	// write channel: okay for mapped, slave error otherwise
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok_r <= 1'b0;
			w_ok_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= 2'h0;
		end else if (ce) begin
			if (awvalid && awready) begin
				aw_ok_r <= 1'b1;
				awaddr_r <= awaddr;
			end
			if (wvalid && wready) begin
				w_ok_r <= 1'b1;
				wdata_r <= wdata;
				wstrb_r <= wstrb;
			end
			if (do_wr) begin
				aw_ok_r <= 1'b0;
				w_ok_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= rf.wr_hit ? 2'h0 : 2'h2;
			end else if (bvalid_r && bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// read channel: data captured at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= 2'h0;
		end else if (ce) begin
			if (do_rd) begin
				rvalid_r <= 1'b1;
				rdata_r <= rf.rd_data;
				rresp_r <= rf.rd_hit ? 2'h0 : 2'h2;
			end else if (rvalid_r && rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ### src/fsp_if.sv
`timescale 1ns/10ps
`default_nettype none
// register access strobes between bus slave and register file
interface fsp_reg_if;
	logic        wr_en;    // one-cycle write strobe
	logic [7:0]  wr_addr;  // write byte address
	logic [31:0] wr_data;  // write data
	logic [3:0]  wr_strb;  // byte enables
	logic        wr_hit;   // write address mapped
	logic [7:0]  rd_addr;  // read byte address
	logic [31:0] rd_data;  // read data for rd_addr
	logic        rd_hit;   // read address mapped
	modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
		input wr_hit, rd_data, rd_hit);
	modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
		output wr_hit, rd_data, rd_hit);
endinterface

// operation timer handshake
interface fsp_tmr_if;
	logic        start;   // one-cycle start pulse
	logic [31:0] cycles;  // duration in clock cycles
	logic        done;    // one-cycle pulse at the end
	modport owner (output start, cycles, input done);
	modport timer (input start, cycles, output done);
endinterface
`default_nettype wire

// ### src/fsp_op_timer.sv
`timescale 1ns/10ps
`default_nettype none
module fsp_op_timer (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ce,
	// control
	fsp_tmr_if.timer  tmr
);
	logic [31:0] cnt_r;   // cycles left
	logic        run_r;   // counting
	logic        done_r;  // end pulse

	assign tmr.done = done_r;

	// ----------------------------------------------------------------
	// down counter, done pulses in the cycle after the last count
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= 32'h0000_0000;
			run_r <= 1'b0;
			done_r <= 1'b0;
		end else if (ce) begin
			done_r <= 1'b0;
			if (tmr.start) begin
				cnt_r <= tmr.cycles;
				run_r <= 1'b1;
			end else if (run_r) begin
				cnt_r <= cnt_r - 32'h0000_0001;
				if (cnt_r <= 32'h0000_0001) begin
					run_r <= 1'b0;
					done_r <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### src/fsp_pkg.sv
package fsp_pkg;
	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL   = 8'h00;  // self_program_control_reg
	localparam logic [7:0] OFF_LOCK   = 8'h04;  // section lock bits
	localparam logic [7:0] OFF_STATUS = 8'h08;  // sticky event bits, write one to clear
	localparam logic [7:0] OFF_MASK   = 8'h0C;  // interrupt mask, same layout
	localparam logic [7:0] OFF_INFO   = 8'h10;  // section boundary, read only

	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int BIT_IE   = 7;  // program_ready_irq_enable
	localparam int BIT_BUSY = 6;  // concurrent_read_busy_flag, read only
	localparam int BIT_RE   = 4;  // read-enable of concurrent_read_section
	localparam int BIT_LOCK = 3;  // lock_bits_set_bit
	localparam int BIT_PW   = 2;  // page write
	localparam int BIT_PE   = 1;  // page erase
	localparam int BIT_EN   = 0;  // self-program enable
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'h9F;  // writable control bits

	// ----------------------------------------------------------------
	// lock, status and mask fields
	// ----------------------------------------------------------------
	localparam int LOCK_APP = 0;  // 1: no erase or write of application section
	localparam int LOCK_LDR = 1;  // 1: no erase or write of loader_section
	localparam logic [1:0] LOCK_RST = 2'h0;
	localparam int STS_DONE = 0;  // an operation completed
	localparam int STS_REFUSED = 1;  // a store was ignored
	localparam logic [1:0] STS_RST = 2'h0;

	// ----------------------------------------------------------------
	// flash geometry and timing
	// ----------------------------------------------------------------
	localparam int FLASH_AW = 13;  // word address width
	localparam int HALT_WORDS = 1024;  // halting_section size at the top
	localparam int LDR_MIN_WORDS = 128;  // smallest loader_section
	localparam int PAGE_WORDS = 64;  // page_size_bytes is twice this
	localparam int CLK_PERIOD_NS = 10;
	localparam int PROG_TIME_NS = 4_000_000;  // erase or write time
	localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_DONE = 2'b11
	} fsp_state_t;
endpackage

// ### src/fsp_top.sv
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - stores fetched from application section are ignored
// - loader stores may target any flash page
// - fuses set boundary; sections lock independently
// - concurrent section programming never stalls core
// - halting section programming stalls core throughout
// - target address, not fetch address, picks mode
// - busy flag set while concurrent section blocked
// - loader section always inside halting section
// - programming per page; fetch stalls only for halting section pages
// - control register layout, all reset zero
module fsp_top #(
	parameter int unsigned PROG_CYCLES = fsp_pkg::PROG_CYCLES,
	parameter int unsigned FLASH_AW    = fsp_pkg::FLASH_AW,
	parameter int unsigned HALT_WORDS  = fsp_pkg::HALT_WORDS,
	parameter int unsigned LDR_MIN     = fsp_pkg::LDR_MIN_WORDS,
	parameter int unsigned PAGE_WORDS  = fsp_pkg::PAGE_WORDS
) (
	// clock, reset, enable
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                ce,
	// axi4-lite register bus
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// core store-to-program-memory request
	input  wire logic                spm_req,
	input  wire logic [FLASH_AW-1:0] spm_pc,
	input  wire logic [FLASH_AW-1:0] spm_addr,
	input  wire logic [15:0]         spm_wdata,
	// fuse pins
	input  wire logic [1:0]          boot_size_fuses,
	// flash array side
	output logic                     flash_erase,
	output logic                     flash_write,
	output logic [FLASH_AW-1:0]      flash_page,
	output logic                     buf_we,
	output logic [FLASH_AW-1:0]      buf_addr,
	output logic [15:0]              buf_data,
	// core side status
	output logic                     core_stall,
	output logic                     concurrent_read_busy_flag,
	output logic                     irq
);
	localparam logic [FLASH_AW-1:0] HALT_START = FLASH_AW'((1 << FLASH_AW) - HALT_WORDS);
	localparam logic [FLASH_AW-1:0] PAGE_MASK  = ~FLASH_AW'(PAGE_WORDS - 1);

	// ----------------------------------------------------------------
	// address helpers
	// ----------------------------------------------------------------
	function automatic logic at_or_above(input logic [FLASH_AW-1:0] a,
		input logic [FLASH_AW-1:0] lim);
		return a >= lim;
	endfunction

	// register offsets that answer okay
	function automatic logic mapped(input logic [7:0] a);
		return (a == fsp_pkg::OFF_CTRL) | (a == fsp_pkg::OFF_LOCK)
			| (a == fsp_pkg::OFF_STATUS) | (a == fsp_pkg::OFF_MASK) | (a == fsp_pkg::OFF_INFO);
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	fsp_pkg::fsp_state_t state_r;  // sequencer state
	logic [7:0] ctrl_r;           // writable control bits, busy kept apart
	logic       busy_r;           // concurrent section blocked
	logic       stall_r;          // halting-section operation running
	logic [1:0] lock_r;           // section locks
	logic [1:0] sts_r;            // sticky events
	logic [1:0] mask_r;           // event mask
	logic [1:0] fz1_r;            // fuse synchroniser, first stage
	logic [1:0] fz2_r;            // fuse synchroniser, second stage
	logic       erase_r;          // flash erase pulse
	logic       write_r;          // flash write pulse
	logic [FLASH_AW-1:0] page_r;  // target page
	logic       bwe_r;            // page buffer write pulse
	logic [FLASH_AW-1:0] baddr_r; // buffer word address
	logic [15:0] bdata_r;         // buffer data

	fsp_reg_if rf ();
	fsp_tmr_if tmr ();

	// ----------------------------------------------------------------
	// section boundaries
	// ----------------------------------------------------------------
	wire [FLASH_AW:0] ldr_raw = (FLASH_AW+1)'(LDR_MIN) << (~fz2_r);
	wire [FLASH_AW:0] ldr_words = (ldr_raw > (FLASH_AW+1)'(HALT_WORDS)) ?
		(FLASH_AW+1)'(HALT_WORDS) : ldr_raw;
	wire [FLASH_AW-1:0] boot_start = FLASH_AW'((1 << FLASH_AW) - ldr_words);

	// ----------------------------------------------------------------
	// store decode
	// ----------------------------------------------------------------
	wire idle      = (state_r == fsp_pkg::ST_IDLE);
	wire en        = ctrl_r[fsp_pkg::BIT_EN];
	wire from_ldr  = at_or_above(spm_pc, boot_start);
	wire tgt_ldr   = at_or_above(spm_addr, boot_start);
	wire tgt_halt  = at_or_above(spm_addr, HALT_START);
	wire tgt_lock  = tgt_ldr ? lock_r[fsp_pkg::LOCK_LDR] : lock_r[fsp_pkg::LOCK_APP];
	wire is_prog   = ctrl_r[fsp_pkg::BIT_PE] | ctrl_r[fsp_pkg::BIT_PW];
	wire store     = ce & spm_req & en & idle;
	wire refuse    = store & (~from_ldr | (is_prog & tgt_lock));
	wire accept    = store & ~refuse;
	wire do_prog   = accept & is_prog;
	wire do_re     = accept & ~is_prog & ctrl_r[fsp_pkg::BIT_RE];
	wire do_lock   = accept & ~is_prog & ~ctrl_r[fsp_pkg::BIT_RE]
		& ctrl_r[fsp_pkg::BIT_LOCK];
	wire do_fill   = accept & ~is_prog & ~ctrl_r[fsp_pkg::BIT_RE]
		& ~ctrl_r[fsp_pkg::BIT_LOCK];
	wire quick     = do_re | do_lock | do_fill;  // single-cycle operations
	wire prog_end  = ce & (state_r == fsp_pkg::ST_DONE);
	wire op_done   = quick | prog_end;

	// ----------------------------------------------------------------
	// register decode and read mux
	// ----------------------------------------------------------------
	wire wr_ctrl = rf.wr_en & rf.wr_strb[0] & (rf.wr_addr == fsp_pkg::OFF_CTRL);
	wire wr_lock = rf.wr_en & rf.wr_strb[0] & (rf.wr_addr == fsp_pkg::OFF_LOCK);
	wire wr_sts  = rf.wr_en & rf.wr_strb[0] & (rf.wr_addr == fsp_pkg::OFF_STATUS);
	wire wr_mask = rf.wr_en & rf.wr_strb[0] & (rf.wr_addr == fsp_pkg::OFF_MASK);
	wire [7:0] ctrl_view = {ctrl_r[7], busy_r, 1'b0, ctrl_r[4:0]};
	wire [1:0] sts_set = {refuse, op_done};

	assign rf.wr_hit = mapped(rf.wr_addr);
	assign rf.rd_hit = mapped(rf.rd_addr);
	always_comb begin
		if (rf.rd_addr == fsp_pkg::OFF_CTRL) begin
			rf.rd_data = {24'h00_0000, ctrl_view};
		end else if (rf.rd_addr == fsp_pkg::OFF_LOCK) begin
			rf.rd_data = {30'h0000_0000, lock_r};
		end else if (rf.rd_addr == fsp_pkg::OFF_STATUS) begin
			rf.rd_data = {30'h0000_0000, sts_r};
		end else if (rf.rd_addr == fsp_pkg::OFF_MASK) begin
			rf.rd_data = {30'h0000_0000, mask_r};
		end else if (rf.rd_addr == fsp_pkg::OFF_INFO) begin
			rf.rd_data = {14'h0000, fz2_r, (16-FLASH_AW)'(0), boot_start};
		end else begin
			rf.rd_data = 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign core_stall = stall_r;
	assign concurrent_read_busy_flag = busy_r;
	assign irq = |(sts_r & mask_r) | (ctrl_r[fsp_pkg::BIT_IE] & ~en);
	assign flash_erase = erase_r;
	assign flash_write = write_r;
	assign flash_page = page_r;
	assign buf_we = bwe_r;
	assign buf_addr = baddr_r;
	assign buf_data = bdata_r;
	assign tmr.start = do_prog;
	assign tmr.cycles = 32'(PROG_CYCLES);

	// ----------------------------------------------------------------
	// fuse pin synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fz1_r <= 2'h0;
			fz2_r <= 2'h0;
		end else if (ce) begin
			fz1_r <= boot_size_fuses;
			fz2_r <= fz1_r;
		end
	end

	// ----------------------------------------------------------------
	// sequencer: idle, timed run, completion
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= fsp_pkg::ST_IDLE;
			stall_r <= 1'b0;
			busy_r <= 1'b0;
		end else if (ce) begin
			case (state_r)
				fsp_pkg::ST_IDLE: begin
					if (do_prog) begin
						state_r <= fsp_pkg::ST_RUN;
						stall_r <= tgt_halt;
						busy_r <= busy_r | ~tgt_halt;
					end else if (do_re) begin
						busy_r <= 1'b0;
					end
				end
				fsp_pkg::ST_RUN: begin
					if (tmr.done) begin
						state_r <= fsp_pkg::ST_DONE;
						stall_r <= 1'b0;
					end
				end
				fsp_pkg::ST_DONE: begin
					state_r <= fsp_pkg::ST_IDLE;
				end
				default: begin
					state_r <= fsp_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// control register: store completion beats software write
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= fsp_pkg::CTRL_RST;
		end else if (ce) begin
			if (op_done) begin
				ctrl_r <= ctrl_r & 8'h80;
			end else if (wr_ctrl && idle) begin
				ctrl_r <= rf.wr_data[7:0] & fsp_pkg::CTRL_WMASK;
			end
		end
	end

	// ----------------------------------------------------------------
	// locks, status, mask; hardware set wins over clear
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_r <= fsp_pkg::LOCK_RST;
			sts_r <= fsp_pkg::STS_RST;
			mask_r <= fsp_pkg::STS_RST;
		end else if (ce) begin
			if (do_lock) begin
				lock_r <= lock_r | spm_wdata[1:0];
			end else if (wr_lock) begin
				lock_r <= lock_r | rf.wr_data[1:0];
			end
			if (wr_sts) begin
				sts_r <= (sts_r & ~rf.wr_data[1:0]) | sts_set;
			end else begin
				sts_r <= sts_r | sts_set;
			end
			if (wr_mask) begin
				mask_r <= rf.wr_data[1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// flash array and page buffer strobes
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			erase_r <= 1'b0;
			write_r <= 1'b0;
			page_r <= '0;
			bwe_r <= 1'b0;
			baddr_r <= '0;
			bdata_r <= 16'h0000;
		end else if (ce) begin
			erase_r <= do_prog & ctrl_r[fsp_pkg::BIT_PE];
			write_r <= do_prog & ~ctrl_r[fsp_pkg::BIT_PE];
			bwe_r <= do_fill;
			if (do_prog) begin
				page_r <= spm_addr & PAGE_MASK;
			end
			if (do_fill) begin
				baddr_r <= spm_addr & ~PAGE_MASK;
				bdata_r <= spm_wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// submodules
	// ----------------------------------------------------------------
	fsp_axil_slave u_bus (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.awaddr  (s_axi_awaddr),
		.awvalid (s_axi_awvalid),
		.awready (s_axi_awready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.wvalid  (s_axi_wvalid),
		.wready  (s_axi_wready),
		.bresp   (s_axi_bresp),
		.bvalid  (s_axi_bvalid),
		.bready  (s_axi_bready),
		.araddr  (s_axi_araddr),
		.arvalid (s_axi_arvalid),
		.arready (s_axi_arready),
		.rdata   (s_axi_rdata),
		.rresp   (s_axi_rresp),
		.rvalid  (s_axi_rvalid),
		.rready  (s_axi_rready),
		.rf      (rf.slave)
	);

	fsp_op_timer u_tmr (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.tmr     (tmr.timer)
	);
endmodule
`default_nettype wire

// ### test/fsp_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module fsp_core_model (
	// clock
	input wire logic        aclk,
	// store request
	output var logic        spm_req,
	output var logic [12:0] spm_pc,
	output var logic [12:0] spm_addr,
	output var logic [15:0] spm_wdata
);
	// quiet core at time zero
	initial begin
		{spm_req, spm_pc, spm_addr, spm_wdata} = '0;
	end
	// single store pulse, second half of the timed pair
	task automatic store(input logic [12:0] pc, a, input logic [15:0] d);
		@(posedge aclk);
		spm_req <= 1'b1;
		spm_pc <= pc;
		spm_addr <= a;
		spm_wdata <= d;
		@(posedge aclk);
		spm_req <= 1'b0;
		// pointer and data are stale once issued
		spm_addr <= ~a;
		spm_wdata <= ~d;
	endtask
endmodule
`default_nettype wire

// ### test/fsp_top_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module fsp_top_monitor #(
	parameter int unsigned FLASH_AW   = 13,
	parameter int unsigned HALT_WORDS = 1024
) (
	// clock and reset
	input wire logic                aclk,
	input wire logic                aresetn,
	// store port and flash side
	input wire logic                spm_req,
	input wire logic [FLASH_AW-1:0] spm_pc,
	input wire logic                flash_erase,
	input wire logic                flash_write,
	input wire logic [FLASH_AW-1:0] flash_page,
	input wire logic                buf_we,
	input wire logic [FLASH_AW-1:0] buf_addr,
	// core side status
	input wire logic                core_stall,
	input wire logic                concurrent_read_busy_flag
);
	// ------------------------------------------------------------
	// store and stall checks
	// ------------------------------------------------------------
	localparam logic [FLASH_AW-1:0] HALT = FLASH_AW'((1 << FLASH_AW) - HALT_WORDS);
	wire logic prog = flash_erase || flash_write;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// stall spans the timed operation
	sequence s_stall_run;
		core_stall [*8] ##1 core_stall ##1 !core_stall;
	endsequence
	property p_stall_run; $rose(core_stall) |-> s_stall_run; endproperty
	a_stall_run: assert property (p_stall_run) else $error("stall length wrong");
	property p_refuse; spm_req && spm_pc < HALT |=> !prog; endproperty
	a_refuse: assert property (p_refuse) else $error("store from application ran");
	property p_cause; prog |-> $past(spm_req); endproperty
	a_cause: assert property (p_cause) else $error("strobe without store");
	property p_conc; prog && flash_page < HALT |-> !core_stall && concurrent_read_busy_flag; endproperty
	a_conc: assert property (p_conc) else $error("concurrent page handled wrong");
	property p_halt; prog && flash_page >= HALT |-> core_stall; endproperty
	a_halt: assert property (p_halt) else $error("halting page did not stall");
	property p_page; prog |-> flash_page[5:0] == 6'h00; endproperty
	a_page: assert property (p_page) else $error("page base unaligned");
	property p_buf; buf_we |-> buf_addr[FLASH_AW-1:6] == '0; endproperty
	a_buf: assert property (p_buf) else $error("buffer word out of page");
	property p_busy; concurrent_read_busy_flag && !spm_req |=> concurrent_read_busy_flag; endproperty
	a_busy: assert property (p_busy) else $error("busy dropped without store");
endmodule
bind fsp_top fsp_top_monitor #(.FLASH_AW(FLASH_AW), .HALT_WORDS(HALT_WORDS)) fsp_top_monitor_i (
	.aclk, .aresetn, .spm_req, .spm_pc, .flash_erase, .flash_write, .flash_page, .buf_we,
	.buf_addr, .core_stall, .concurrent_read_busy_flag);
`default_nettype wire

// ### test/fsp_top_test.sv
`timescale 1ns/10ps
`default_nettype none
module fsp_top_test;
	// ------------------------------------------------------------
	// bench signals
	// ------------------------------------------------------------
	logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, spm_req, core_stall, concurrent_read_busy_flag, irq;
	logic        flash_erase, flash_write, buf_we, stl, bsy;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, boot_size_fuses, rs;
	logic [12:0] spm_pc, spm_addr, flash_page, buf_addr, pg, ba;
	logic [15:0] spm_wdata, buf_data, bd;
	int          miscompares, tests_run, cyc, ecnt, wcnt;
	fsp_top #(.PROG_CYCLES(8)) fsp_top_i (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .spm_req, .spm_pc, .spm_addr,
		.spm_wdata, .boot_size_fuses, .flash_erase, .flash_write, .flash_page, .buf_we,
		.buf_addr, .buf_data, .core_stall, .concurrent_read_busy_flag, .irq);
	fsp_core_model fsp_core_model_i (.aclk, .spm_req, .spm_pc, .spm_addr, .spm_wdata);
	// 100 MHz clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// strobe capture and hang guard
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (flash_erase || flash_write) begin
			ecnt <= ecnt + int'(flash_erase);
			wcnt <= wcnt + int'(flash_write);
			pg <= flash_page;
			stl <= core_stall;
			bsy <= concurrent_read_busy_flag;
		end
		if (buf_we) {ba, bd} <= {buf_addr, buf_data};
		if (cyc == 5000) begin
			miscompares++;
			conclude();
		end
	end
	task automatic chk(input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// axi4-lite write, aw and w together
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit ad = 0, wd = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (!ad && s_axi_awready === 1'b1) begin
				ad = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wd && s_axi_wready === 1'b1) begin
				wd = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// axi4-lite read
	task automatic rdr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rdr(a);
		chk(rd, e);
	endtask
	// poll until the enable bit reads zero
	task automatic idle;
		do rdr(fsp_pkg::OFF_CTRL); while (rd[0] !== 1'b0);
	endtask
	task automatic do_spm(input logic [7:0] c, input logic [12:0] p, a);
		idle();
		wr(fsp_pkg::OFF_CTRL, 32'(c));
		fsp_core_model_i.store(p, a, 16'hA5C3);
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		ce = 1'b1;
		s_axi_wstrb = 4'hF;
		boot_size_fuses = 2'b11;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(fsp_pkg::OFF_CTRL, 32'h0000_0000);
		rchk(8'h20, 32'h0000_0000);
		chk(32'(rs), 32'h0000_0002);
		rchk(fsp_pkg::OFF_INFO, 32'h0003_1F80);
		boot_size_fuses <= 2'b00;
		repeat (4) @(posedge aclk);
		rchk(fsp_pkg::OFF_INFO, 32'h0000_1C00);
		boot_size_fuses <= 2'b11;
		repeat (4) @(posedge aclk);
		$display("test map done");
		wr(fsp_pkg::OFF_CTRL, 32'h0000_0003);
		fsp_core_model_i.store(13'h0100, 13'h0040, 16'h1234);
		repeat (3) @(posedge aclk);
		chk(32'(ecnt), 32'h0000_0000);
		rchk(fsp_pkg::OFF_STATUS, 32'h0000_0002);
		wr(fsp_pkg::OFF_STATUS, 32'h0000_0003);
		wr(fsp_pkg::OFF_CTRL, 32'h0000_0000);
		wr(fsp_pkg::OFF_MASK, 32'h0000_0001);
		$display("test refuse done");
		do_spm(8'h03, 13'h1F80, 13'h0045);
		rchk(fsp_pkg::OFF_CTRL, 32'h0000_0043);
		idle();
		chk(32'(pg), 32'h0000_0040);
		chk(32'({stl, bsy}), 32'h0000_0001);
		rchk(fsp_pkg::OFF_CTRL, 32'h0000_0040);
		chk(32'(irq), 32'h0000_0001);
		wr(fsp_pkg::OFF_STATUS, 32'h0000_0001);
		chk(32'(irq), 32'h0000_0000);
		wr(fsp_pkg::OFF_MASK, 32'h0000_0000);
		do begin
			do_spm(8'h11, 13'h1F80, 13'h0000);
			idle();
		end while (rd[6] !== 1'b0);
		chk(rd, 32'h0000_0000);
		chk(32'(irq), 32'h0000_0000);
		$display("test conc done");
		wr(fsp_pkg::OFF_LOCK, 32'h0000_0001);
		do_spm(8'h03, 13'h1F80, 13'h0040);
		repeat (3) @(posedge aclk);
		chk(32'(ecnt), 32'h0000_0001);
		wr(fsp_pkg::OFF_CTRL, 32'h0000_0000);
		do_spm(8'h05, 13'h1F80, 13'h1F85);
		idle();
		chk(32'(wcnt), 32'h0000_0001);
		chk(32'({pg, stl}), 32'h0000_3F01);
		do_spm(8'h01, 13'h1F80, 13'h1F87);
		idle();
		chk(32'({ba, bd}), 32'h0007_A5C3);
		do_spm(8'h09, 13'h1F80, 13'h0000);
		rchk(fsp_pkg::OFF_LOCK, 32'h0000_0003);
		$display("test halt done");
		conclude();
	end
endmodule
`default_nettype wire
